// ==== design/srelc_cfg.svh ====
// Purpose: Constants for the reset, enable and limp-home controller
// Assumes: 250 MHz pclk; APB register map is local to this block
// Notes:   Long counts are top-level parameters; these are defaults
`ifndef SRELC_CFG_SVH
`define SRELC_CFG_SVH

// Register byte offsets
`define SRELC_OFF_CTRL      12'h000
`define SRELC_OFF_IRQ       12'h004
`define SRELC_OFF_STATUS    12'h008
`define SRELC_OFF_EVENT     12'h00C

// Control register fields
`define SRELC_CTRL_MODE_LO  0
`define SRELC_CTRL_ENC      2
`define SRELC_CTRL_LIMP_WARNING_BIT     3
`define SRELC_CTRL_LHC      4
`define SRELC_CTRL_SWR      5
`define SRELC_CTRL_WMC      6
`define SRELC_CTRL_RESET_THRESHOLD_SEL     7
`define SRELC_CTRL_STBC     8
`define SRELC_CTRL_STBL     9
`define SRELC_CTRL_WIC_LO   10
`define SRELC_CTRL_NWP_LO   14

// Interrupt flag positions
`define SRELC_IRQ_MCU_SUPPLY_UV_IRQ      11
`define SRELC_IRQ_XCVR_SUPPLY_UV_IRQ      10
`define SRELC_IRQ_CI        7
`define SRELC_IRQ_POWER_ON_IRQ_FLAG      5

// Mode codes
`define SRELC_MODE_STANDBY  2'h0
`define SRELC_MODE_SLEEP    2'h1
`define SRELC_MODE_NORM_OFF 2'h2
`define SRELC_MODE_NORM_ON  2'h3

// Reset values
`define SRELC_NWP_DEFAULT   3'h4
`define SRELC_IRQ_RESET     16'h0020

// Timing in nanoseconds and cycle counts
`define SRELC_CLK_NS        4
`define SRELC_T_FILTER_NS   10000
`define SRELC_FILTER_CYC    ((`SRELC_T_FILTER_NS + `SRELC_CLK_NS - 1) / `SRELC_CLK_NS)
`define SRELC_T_SHORT_NS    20000000
`define SRELC_T_LONG_NS     40000000
`define SRELC_SHORT_CYC     ((`SRELC_T_SHORT_NS + `SRELC_CLK_NS - 1) / `SRELC_CLK_NS)
`define SRELC_LONG_CYC      ((`SRELC_T_LONG_NS + `SRELC_CLK_NS - 1) / `SRELC_CLK_NS)

`endif

// ==== design/srelc_pkg.sv ====
// Purpose: Types for the reset, enable and limp-home controller
// Assumes: Constants come from srelc_cfg.svh
// Notes:   Struct groups the analog and watchdog event inputs
package srelc_pkg;

    typedef enum logic [2:0] {
        SRELC_IDLE  = 3'b001,
        SRELC_PULSE = 3'b010,
        SRELC_HOLD  = 3'b100
    } srelc_state_t;

    typedef struct packed {
        logic vbat_above_pon;
        logic overtemp;
        logic mcu_uv_90;
        logic mcu_uv_70;
        logic xcvr_uv_90;
        logic wdog_overflow;
        logic wdog_early_trig;
        logic wake_pending;
    } srelc_events_t;

endpackage : srelc_pkg

// ==== design/srelc_top.sv ====
// Purpose: System reset sequencer, enable output and limp-home logic
// Assumes: APB slave on pclk; analog and watchdog events arrive synchronous
// Notes:   Timing from pclk stands in for the internal oscillator
`timescale 1ns/10ps
`include "srelc_cfg.svh"

// Summary of operation
// - Sleep request while unsafe causes reset
// - Watchdog window faults, double timeout reset
// - Mode bit change in normal, or disable pin change, resets
// - Software reset bit forces full reset
// - Leaving overtemperature resets with strapped length
// - Timeout overflow without pending flag sets it
// - Filtered external low on reset pin resets
// - Internal reset drives reset pin low
// - Supply, power-on, overtemp resets use strap length
// - All other internal causes use short pulse
// - Enable pin high when bit set, normal mode
// - Any reset forces enable output low
// - Reset sets warning; second reset sets limp
// - Overtemperature holds limp bit set
// - Low battery enters off; recovery to standby
// - Leaving off sets power-on flag
// - Supply undervoltage resets at selected threshold
// - Supply warning flag at ninety percent
// - Supply status bit readable
// - Mode code 10 disables transceiver regulator
// - Transceiver supply warning at ninety percent
// - Transceiver status real only in normal
// - Write one clears interrupt flags
// - Codes 1x normal, 00 standby, 01 sleep
// - Watchdog reset restores default period
module srelc_top #(
    parameter int unsigned SHORT_CYC  = `SRELC_SHORT_CYC,
    parameter int unsigned LONG_CYC   = `SRELC_LONG_CYC,
    parameter int unsigned FILTER_CYC = `SRELC_FILTER_CYC
) (
    // Clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Analog, watchdog and pin events
    input  wire srelc_pkg::srelc_events_t evt,
    input  wire logic                   wdog_disable_pin,
    input  wire logic                   irq_out_n,
    input  wire logic                   short_strap,
    // Bidirectional reset pin, active low
    input  wire logic                   sys_reset_pin_n_in,
    output logic                        sys_reset_pin_n_out,
    output logic                        sys_reset_pin_n_oe,
    // Fail-safe outputs
    output logic                        enable_out,
    output logic                        limp_out_n_oe,
    output logic                        xcvr_supply_regulator_on,
    output logic                        power_off_mode
);

    localparam int unsigned CW = 24;

    srelc_pkg::srelc_state_t state_r;
    logic [1:0]  mode_field_r;
    logic        enable_out_ctrl_r;
    logic        limp_warning_bit_r;
    logic        limp_active_bit_r;
    logic        wdog_mode_ctrl_bit_r;
    logic        reset_threshold_sel_r;
    logic        can_xcvr_standby_bit_r;
    logic        lin_xcvr_standby_bit_r;
    logic [1:0]  wake_pin1_config_r;
    logic [1:0]  wake_pin2_config_r;
    logic [2:0]  wdog_period_sel_r;
    logic [15:0] irq_r;
    logic [CW-1:0] pulse_cnt_r;
    logic [CW-1:0] filt_cnt_r;
    logic        ext_seen_r;
    logic        wdog_disable_pin_r;
    logic        ot_r;
    logic        poff_r;
    logic [7:0]  cause_r;

    function automatic logic is_normal(input logic [1:0] m);
        is_normal = m[1];
    endfunction : is_normal

    function automatic logic [CW-1:0] cyc(input int unsigned n);
        cyc = CW'(n);
    endfunction : cyc

    // APB decode; single-cycle access, always ready
    logic apb_wr;
    logic wr_ctrl;
    logic wr_irq;
    logic [15:0] wsel;
    assign apb_wr  = psel && penable && pwrite;
    assign wr_ctrl = apb_wr && (paddr == `SRELC_OFF_CTRL);
    assign wr_irq  = apb_wr && (paddr == `SRELC_OFF_IRQ);
    assign wsel    = pwdata[15:0];

    // Watchdog mode decode
    logic wd_on;
    logic wd_window;
    logic wd_timeout;
    logic wmc_new;
    assign wd_on      = !wdog_disable_pin && !poff_r && !evt.overtemp;
    assign wd_window  = wd_on && is_normal(mode_field_r) && !wdog_mode_ctrl_bit_r;
    assign wd_timeout = wd_on && (is_normal(mode_field_r) ? wdog_mode_ctrl_bit_r
                                 : (mode_field_r == `SRELC_MODE_STANDBY)
                                   && !wdog_mode_ctrl_bit_r);
    assign wmc_new    = wsel[`SRELC_CTRL_WMC];

    // Reset causes
    logic [1:0] mode_wr;
    logic sleep_bad;
    logic c_wdog;
    logic c_wmc;
    logic c_wdog_disable_pin;
    logic c_swr;
    logic c_ot;
    logic c_uv;
    logic c_pon;
    logic c_ext;
    logic ext_low;
    logic any_int;
    logic any_rst;
    logic use_strap;
    logic ci_req;
    assign mode_wr   = wsel[`SRELC_CTRL_MODE_LO +: 2];
    assign sleep_bad = !irq_out_n
                     || ({wsel[`SRELC_CTRL_STBC], wsel[`SRELC_CTRL_STBL],
                          wsel[`SRELC_CTRL_WIC_LO +: 4]} == 6'h00)
                     || evt.wake_pending;
    assign c_wdog  = (wd_window && (evt.wdog_overflow || evt.wdog_early_trig))
                   || (wd_timeout && evt.wdog_overflow && irq_r[`SRELC_IRQ_CI]);
    assign ci_req  = wd_timeout && evt.wdog_overflow && !irq_r[`SRELC_IRQ_CI];
    assign c_wmc   = wr_ctrl && is_normal(mode_field_r)
                   && (wmc_new != wdog_mode_ctrl_bit_r);
    assign c_wdog_disable_pin = (wdog_disable_pin != wdog_disable_pin_r);
    assign c_swr   = wr_ctrl && wsel[`SRELC_CTRL_SWR];
    assign c_ot    = ot_r && !evt.overtemp;
    assign c_uv    = reset_threshold_sel_r ? evt.mcu_uv_70 : evt.mcu_uv_90;
    assign c_pon   = poff_r && evt.vbat_above_pon;
    assign ext_low = !sys_reset_pin_n_in && !sys_reset_pin_n_oe;
    assign c_ext   = ext_low && (filt_cnt_r == cyc(FILTER_CYC - 1)) && !ext_seen_r;
    // Logic is down in off mode; only the power-on cause gets through
    assign any_int = ((wr_ctrl && (mode_wr == `SRELC_MODE_SLEEP) && sleep_bad)
                   || c_wdog || c_wmc || c_wdog_disable_pin || c_swr || c_ot || c_uv || c_pon)
                   && (!poff_r || c_pon);
    assign any_rst = any_int || (c_ext && !poff_r);
    assign use_strap = c_ot || c_uv || c_pon;

    // External reset filter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_cnt_r <= '0;
            ext_seen_r <= 1'b0;
        end else if (!ext_low) begin
            filt_cnt_r <= '0;
            ext_seen_r <= 1'b0;
        end else begin
            if (filt_cnt_r != cyc(FILTER_CYC - 1))
                filt_cnt_r <= filt_cnt_r + 1'b1;
            if (c_ext)
                ext_seen_r <= 1'b1;
        end
    end

    logic poff_nxt;
    assign poff_nxt = !evt.vbat_above_pon;

    // Event history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_disable_pin_r <= 1'b0;
            ot_r    <= 1'b0;
            poff_r  <= 1'b1;
        end else begin
            wdog_disable_pin_r <= wdog_disable_pin;
            ot_r    <= evt.overtemp;
            poff_r  <= poff_nxt;
        end
    end

    // Pulse generator; any new internal cause restarts the count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r     <= srelc_pkg::SRELC_IDLE;
            pulse_cnt_r <= '0;
            cause_r     <= '0;
        end else if (any_int) begin
            state_r     <= srelc_pkg::SRELC_PULSE;
            pulse_cnt_r <= (use_strap && !short_strap) ? cyc(LONG_CYC - 1)
                                                       : cyc(SHORT_CYC - 1);
            cause_r     <= {c_ext, c_pon, c_uv, c_ot, c_swr, c_wdog_disable_pin | c_wmc, c_wdog,
                            !(c_pon | c_uv | c_ot | c_swr | c_wdog_disable_pin | c_wmc | c_wdog)};
        end else begin
            unique case (state_r)
                srelc_pkg::SRELC_IDLE: begin
                    if (c_ext) begin
                        state_r <= srelc_pkg::SRELC_HOLD;
                        cause_r <= 8'h80;
                    end
                end
                srelc_pkg::SRELC_PULSE: begin
                    if (pulse_cnt_r == '0)
                        state_r <= srelc_pkg::SRELC_IDLE;
                    else
                        pulse_cnt_r <= pulse_cnt_r - 1'b1;
                end
                srelc_pkg::SRELC_HOLD: begin
                    if (!ext_low)
                        state_r <= srelc_pkg::SRELC_IDLE;
                end
            endcase
        end
    end

    // Control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_field_r           <= `SRELC_MODE_STANDBY;
            enable_out_ctrl_r      <= 1'b0;
            wdog_mode_ctrl_bit_r   <= 1'b0;
            reset_threshold_sel_r  <= 1'b0;
            can_xcvr_standby_bit_r <= 1'b0;
            lin_xcvr_standby_bit_r <= 1'b0;
            wake_pin1_config_r     <= 2'h0;
            wake_pin2_config_r     <= 2'h0;
            wdog_period_sel_r      <= `SRELC_NWP_DEFAULT;
        end else if (any_rst || poff_r) begin
            mode_field_r      <= `SRELC_MODE_STANDBY;
            enable_out_ctrl_r <= 1'b0;
            if (c_wdog || c_wmc || c_wdog_disable_pin)
                wdog_period_sel_r <= `SRELC_NWP_DEFAULT;
        end else if (wr_ctrl) begin
            mode_field_r           <= mode_wr;
            enable_out_ctrl_r      <= wsel[`SRELC_CTRL_ENC];
            wdog_mode_ctrl_bit_r   <= wmc_new;
            reset_threshold_sel_r  <= wsel[`SRELC_CTRL_RESET_THRESHOLD_SEL];
            can_xcvr_standby_bit_r <= wsel[`SRELC_CTRL_STBC];
            lin_xcvr_standby_bit_r <= wsel[`SRELC_CTRL_STBL];
            wake_pin1_config_r     <= wsel[`SRELC_CTRL_WIC_LO +: 2];
            wake_pin2_config_r     <= wsel[`SRELC_CTRL_WIC_LO + 2 +: 2];
            wdog_period_sel_r      <= wsel[`SRELC_CTRL_NWP_LO +: 3];
        end
    end

    // Limp-home pair; hardware set wins over software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            limp_warning_bit_r <= 1'b0;
            limp_active_bit_r  <= 1'b0;
        end else begin
            if (any_rst)
                limp_warning_bit_r <= 1'b1;
            else if (wr_ctrl)
                limp_warning_bit_r <= wsel[`SRELC_CTRL_LIMP_WARNING_BIT];
            if ((any_rst && limp_warning_bit_r) || evt.overtemp)
                limp_active_bit_r <= 1'b1;
            else if (wr_ctrl)
                limp_active_bit_r <= wsel[`SRELC_CTRL_LHC];
        end
    end

    // Interrupt flags; set wins over write-one clear
    logic [15:0] irq_set;
    always_comb begin
        irq_set = '0;
        irq_set[`SRELC_IRQ_MCU_SUPPLY_UV_IRQ] = evt.mcu_uv_90;
        // Still watched in mode 10 with the regulator off, but not in off mode; an outside source may feed it
        irq_set[`SRELC_IRQ_XCVR_SUPPLY_UV_IRQ] = evt.xcvr_uv_90 && !poff_r;
        irq_set[`SRELC_IRQ_CI]   = ci_req;
        irq_set[`SRELC_IRQ_POWER_ON_IRQ_FLAG] = c_pon;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq_r <= `SRELC_IRQ_RESET;
        else
            irq_r <= (irq_r & ~(wr_irq ? wsel : 16'h0000)) | irq_set;
    end

    // Pin and status outputs, all registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_reset_pin_n_out      <= 1'b0;
            sys_reset_pin_n_oe       <= 1'b0;
            enable_out               <= 1'b0;
            limp_out_n_oe            <= 1'b0;
            xcvr_supply_regulator_on <= 1'b0;
            power_off_mode           <= 1'b1;
        end else begin
            sys_reset_pin_n_out <= 1'b0;
            // Gated on the next off state so off mode and outputs switch together
            sys_reset_pin_n_oe  <= ((state_r == srelc_pkg::SRELC_PULSE) || any_int)
                                   && !poff_nxt;
            enable_out          <= enable_out_ctrl_r && is_normal(mode_field_r)
                                   && !any_rst && !poff_nxt;
            limp_out_n_oe       <= limp_active_bit_r;
            xcvr_supply_regulator_on <= (mode_field_r != `SRELC_MODE_NORM_OFF)
                                        && !poff_nxt;
            power_off_mode      <= poff_nxt;
        end
    end

    // APB read data
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        unique case (paddr)
            `SRELC_OFF_CTRL: begin
                rd_mux[`SRELC_CTRL_MODE_LO +: 2] = mode_field_r;
                rd_mux[`SRELC_CTRL_ENC]  = enable_out_ctrl_r;
                rd_mux[`SRELC_CTRL_LIMP_WARNING_BIT] = limp_warning_bit_r;
                rd_mux[`SRELC_CTRL_LHC]  = limp_active_bit_r;
                rd_mux[`SRELC_CTRL_WMC]  = wdog_mode_ctrl_bit_r;
                rd_mux[`SRELC_CTRL_RESET_THRESHOLD_SEL] = reset_threshold_sel_r;
                rd_mux[`SRELC_CTRL_STBC] = can_xcvr_standby_bit_r;
                rd_mux[`SRELC_CTRL_STBL] = lin_xcvr_standby_bit_r;
                rd_mux[`SRELC_CTRL_WIC_LO +: 4] = {wake_pin2_config_r, wake_pin1_config_r};
                rd_mux[`SRELC_CTRL_NWP_LO +: 3] = wdog_period_sel_r;
            end
            `SRELC_OFF_IRQ:    rd_mux[15:0] = irq_r;
            `SRELC_OFF_STATUS: begin
                rd_mux[0] = !evt.mcu_uv_90;
                rd_mux[1] = is_normal(mode_field_r) ? !evt.xcvr_uv_90 : 1'b1;
                rd_mux[2] = (state_r != srelc_pkg::SRELC_IDLE);
            end
            `SRELC_OFF_EVENT:  rd_mux[7:0] = cause_r;
            default:           rd_mux = '0;
        endcase
    end

    logic mapped;
    assign mapped = (paddr == `SRELC_OFF_CTRL) || (paddr == `SRELC_OFF_IRQ)
                  || (paddr == `SRELC_OFF_STATUS) || (paddr == `SRELC_OFF_EVENT);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

endmodule : srelc_top

// ==== bench/srelc_top_props.sv ====
// Purpose: Port-level checks for the reset, enable and limp-home controller
// Assumes: Zero-wait APB slave; a master that always follows setup with access
// Notes:   Pulse and filter lengths are counted in helper counters
`timescale 1ns/10ps
`include "srelc_cfg.svh"
module srelc_top_props #(
    parameter int unsigned SHORT_CYC  = 20,
    parameter int unsigned LONG_CYC   = 40,
    parameter int unsigned FILTER_CYC = 4
) (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins
    input wire logic        sys_reset_pin_n_in,
    input wire logic        sys_reset_pin_n_out,
    input wire logic        sys_reset_pin_n_oe,
    input wire logic        enable_out,
    input wire logic        xcvr_supply_regulator_on,
    input wire logic        power_off_mode
);
    logic [31:0] pulse_cnt_r;
    logic [31:0] low_cnt_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pulse_cnt_r <= '0;
        else          pulse_cnt_r <= sys_reset_pin_n_oe ? pulse_cnt_r + 32'h0000_0001 : '0;
    end

    // Only host-driven lows count toward the filter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) low_cnt_r <= '0;
        else if (!sys_reset_pin_n_in && !sys_reset_pin_n_oe) low_cnt_r <= low_cnt_r + 32'h0000_0001;
        else low_cnt_r <= '0;
    end

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && pready;
    endsequence

    a_apb_zero_wait: assert property (s_setup |=> s_access)
        else $error("pready missing in access cycle");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_slverr_unmapped: assert property (pready |-> (pslverr == !(paddr inside {`SRELC_OFF_CTRL,
        `SRELC_OFF_IRQ, `SRELC_OFF_STATUS, `SRELC_OFF_EVENT})))
        else $error("pslverr does not match address decode");
    a_pulse_drives_low: assert property (sys_reset_pin_n_oe |-> !sys_reset_pin_n_out && !enable_out)
        else $error("reset pulse not low or enable high during pulse");
    a_pulse_min_len: assert property ($fell(sys_reset_pin_n_oe) |-> pulse_cnt_r >= SHORT_CYC)
        else $error("reset pulse shorter than short length");
    a_ext_filter: assert property ((low_cnt_r == FILTER_CYC) |-> ##[0:2] !enable_out)
        else $error("filtered external reset did not drop enable");
    a_off_quiet: assert property (power_off_mode |-> !enable_out && !xcvr_supply_regulator_on && !sys_reset_pin_n_oe)
        else $error("outputs active in off mode");
    a_pulse_after_off: assert property ($fell(power_off_mode) |-> ##[0:2] sys_reset_pin_n_oe)
        else $error("no reset pulse on leaving off mode");
endmodule : srelc_top_props

// ==== bench/srelc_host_model.sv ====
// Purpose: Host side of the bidirectional reset pin
// Assumes: Pin carries a pull-up strap to the supply
// Notes:   Either party may pull low; the strap restores high
`timescale 1ns/10ps
module srelc_host_model (
    // Device side
    input  wire logic dev_out,
    input  wire logic dev_oe,
    // Host request
    input  wire logic host_hold_low,
    // Resolved pin
    output logic      pin_level
);
    // Wired-AND: a released pin never keeps a stale low
    assign pin_level = !(host_hold_low || (dev_oe && !dev_out));
endmodule : srelc_host_model

// ==== bench/srelc_top_test.sv ====
// Purpose: Self-checking bench for the reset, enable and limp-home controller
// Assumes: Small pulse and filter counts; zero-wait APB
// Notes:   Pulse lengths measured from the reset pin enable
`timescale 1ns/10ps
`include "srelc_cfg.svh"
module srelc_top_test;
    localparam int unsigned SHORT_CYC  = 20;
    localparam int unsigned LONG_CYC   = 40;
    localparam int unsigned FILTER_CYC = 4;
    logic                     pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
    logic [11:0]              paddr;
    logic [31:0]              pwdata, prdata, rd;
    logic [31:0]              last_len = '0;
    srelc_pkg::srelc_events_t evt;
    logic                     wdog_disable_pin, irq_out_n, short_strap, hold_low, pin_level;
    logic                     rst_out, rst_oe, enable_out, limp_oe, reg_on, off_mode;
    int                       hi_cnt = 0, err_count, compares;

    srelc_top #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC), .FILTER_CYC(FILTER_CYC)) srelc_top_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .evt(evt), .wdog_disable_pin(wdog_disable_pin), .irq_out_n(irq_out_n),
        .short_strap(short_strap), .sys_reset_pin_n_in(pin_level), .sys_reset_pin_n_out(rst_out),
        .sys_reset_pin_n_oe(rst_oe), .enable_out(enable_out), .limp_out_n_oe(limp_oe),
        .xcvr_supply_regulator_on(reg_on), .power_off_mode(off_mode));
    srelc_host_model srelc_host_model_i (.dev_out(rst_out), .dev_oe(rst_oe),
        .host_hold_low(hold_low), .pin_level(pin_level));

    always #2 pclk = ~pclk;

    // Length of the last completed pulse, in cycles
    always @(posedge pclk) begin
        hi_cnt <= rst_oe ? hi_cnt + 1 : 0;
        if (!rst_oe && hi_cnt != 0) last_len <= 32'(hi_cnt);
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask : chk_bit

    // Setup, access until pready, release, two idle edges
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask : apb

    task automatic rdw(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk_word(rd, exp);
    endtask : rdw

    task automatic pulse(input int unsigned exp);
        int n;
        n = 0;
        while (rst_oe !== 1'b1 && n < 10) begin
            @(posedge pclk);
            n++;
        end
        chk_bit(rst_oe, 1'b1);
        while (rst_oe === 1'b1) @(posedge pclk);
        @(posedge pclk);
        // Pin is driven in the cause cycle, then for the full count
        chk_word(last_len, 32'(exp + 1));
    endtask : pulse

    task automatic test_done;
        $display("Mismatches %0d, comparisons %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : test_done

    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        test_done();
    end

    initial begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = '0; evt = '0; wdog_disable_pin = 1'b0; irq_out_n = 1'b1;
        short_strap = 1'b0; hold_low = 1'b0;
        err_count = 0; compares = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk_bit(off_mode, 1'b1);
        evt.vbat_above_pon <= 1'b1;
        pulse(LONG_CYC);
        rdw(`SRELC_OFF_EVENT, 32'h0000_0040);
        rdw(`SRELC_OFF_IRQ, 32'h0000_0020);
        apb(1'b1, `SRELC_OFF_IRQ, 32'h0000_0020);
        rdw(`SRELC_OFF_IRQ, 32'h0000_0000);
        rdw(`SRELC_OFF_CTRL, 32'h0001_0008);
        apb(1'b1, `SRELC_OFF_CTRL, 32'h0000_0007);
        chk_bit(enable_out, 1'b1);
        chk_bit(reg_on, 1'b1);
        evt.xcvr_uv_90 <= 1'b1;
        apb(1'b1, `SRELC_OFF_CTRL, 32'h0000_0006);
        chk_bit(reg_on, 1'b0);
        apb(1'b1, `SRELC_OFF_IRQ, 32'h0000_0400);
        rdw(`SRELC_OFF_IRQ, 32'h0000_0400);
        rdw(`SRELC_OFF_STATUS, 32'h0000_0001);
        apb(1'b1, `SRELC_OFF_CTRL, 32'h0000_0004);
        chk_bit(enable_out, 1'b0);
        rdw(`SRELC_OFF_STATUS, 32'h0000_0003);
        rdw(`SRELC_OFF_IRQ, 32'h0000_0400);
        evt.xcvr_uv_90 <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, `SRELC_OFF_CTRL, i == 0 ? 32'h0000_0023 : 32'h0000_002B);
            pulse(SHORT_CYC);
            chk_bit(limp_oe, i == 1);
            rdw(`SRELC_OFF_EVENT, 32'h0000_0008);
        end
        apb(1'b1, `SRELC_OFF_CTRL, 32'h0000_0003);
        chk_bit(limp_oe, 1'b0);
        evt.wdog_early_trig <= 1'b1;
        @(posedge pclk);
        evt.wdog_early_trig <= 1'b0;
        pulse(SHORT_CYC);
        rdw(`SRELC_OFF_EVENT, 32'h0000_0002);
        apb(1'b0, `SRELC_OFF_CTRL, 32'h0000_0000);
        chk_word({29'h0, rd[16:14]}, 32'h0000_0004);
        apb(1'b1, `SRELC_OFF_CTRL, 32'h0000_0003);
        apb(1'b1, `SRELC_OFF_CTRL, 32'h0000_0043);
        pulse(SHORT_CYC);
        rdw(`SRELC_OFF_EVENT, 32'h0000_0004);
        apb(1'b1, `SRELC_OFF_IRQ, 32'h0000_FFFF);
        apb(1'b1, `SRELC_OFF_CTRL, 32'h0000_0000);
        for (int i = 0; i < 2; i++) begin
            evt.wdog_overflow <= 1'b1;
            @(posedge pclk);
            evt.wdog_overflow <= 1'b0;
            if (i == 0) rdw(`SRELC_OFF_IRQ, 32'h0000_0080);
            else pulse(SHORT_CYC);
        end
        apb(1'b1, `SRELC_OFF_CTRL, 32'h0000_0001);
        pulse(SHORT_CYC);
        rdw(`SRELC_OFF_EVENT, 32'h0000_0001);
        apb(1'b1, `SRELC_OFF_CTRL, 32'h0000_0083);
        evt.mcu_uv_90 <= 1'b1;
        rdw(`SRELC_OFF_STATUS, 32'h0000_0002);
        apb(1'b0, `SRELC_OFF_IRQ, 32'h0000_0000);
        chk_bit(rd[11], 1'b1);
        evt.mcu_uv_70 <= 1'b1;
        @(posedge pclk);
        evt.mcu_uv_70 <= 1'b0;
        evt.mcu_uv_90 <= 1'b0;
        pulse(LONG_CYC);
        rdw(`SRELC_OFF_EVENT, 32'h0000_0020);
        short_strap <= 1'b1;
        evt.overtemp <= 1'b1;
        repeat (3) @(posedge pclk);
        chk_bit(limp_oe, 1'b1);
        evt.overtemp <= 1'b0;
        pulse(SHORT_CYC);
        rdw(`SRELC_OFF_EVENT, 32'h0000_0010);
        apb(1'b1, `SRELC_OFF_CTRL, 32'h0000_0007);
        for (int i = 0; i < 2; i++) begin
            hold_low <= 1'b1;
            repeat (i == 0 ? FILTER_CYC - 1 : FILTER_CYC + 2) @(posedge pclk);
            hold_low <= 1'b0;
            repeat (4) @(posedge pclk);
            rdw(`SRELC_OFF_EVENT, i == 0 ? 32'h0000_0010 : 32'h0000_0080);
            chk_bit(enable_out, i == 0);
        end
        rdw(12'h010, 32'h0000_0000);
        chk_bit(slv, 1'b1);
        test_done();
    end
endmodule : srelc_top_test

bind srelc_top srelc_top_props #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC),
    .FILTER_CYC(FILTER_CYC)) srelc_top_props_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .sys_reset_pin_n_in(sys_reset_pin_n_in), .sys_reset_pin_n_out(sys_reset_pin_n_out),
    .sys_reset_pin_n_oe(sys_reset_pin_n_oe), .enable_out(enable_out),
    .xcvr_supply_regulator_on(xcvr_supply_regulator_on), .power_off_mode(power_off_mode));
